// >>> core/ppp_printer_port.sv
// ==========================================
`timescale 1ns/1ps
`default_nettype none

module ppp_printer_port (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic mode_jumper_in,
	input wire logic send_valid_in,
	input wire logic [ppp_pkg::PPP_DATA_W-1:0] send_byte_in,
	output logic send_ready_out,
	input wire logic [7:4] status_pins_in,
	output logic [ppp_pkg::PPP_DATA_W-1:0] printer_byte_out,
	output logic [3:0] ctrl_pins_out,
	output ppp_pkg::ppp_status_t status_out,
	output ppp_pkg::ppp_mode_t mode_out
);
	import ppp_pkg::*;

	logic [7:4] stat_meta_reg;
	logic [7:4] stat_sync_reg;
	logic jmp_meta_reg;
	logic jmp_sync_reg;
	logic [1:0] settle_reg;
	logic mode_taken_reg;
	ppp_mode_t mode_reg;
	ppp_state_t state_reg;
	logic [PPP_CNT_W-1:0] cnt_reg;
	logic [PPP_DATA_W-1:0] byte_reg;
	logic strobe_reg;
	ppp_status_t status_reg;
	logic busy_now;
	logic take_now;
	logic cnt_done;
	logic strobe_start;

	// ==========================================
	// Input synchronisers

	// Status pins pass two flip-flops before use.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stat_meta_reg <= 4'h0;
			stat_sync_reg <= 4'h0;
			jmp_meta_reg <= 1'b0;
			jmp_sync_reg <= 1'b0;
		end else begin
			stat_meta_reg <= status_pins_in;
			stat_sync_reg <= stat_meta_reg;
			jmp_meta_reg <= mode_jumper_in;
			jmp_sync_reg <= jmp_meta_reg;
		end
	end

	// ==========================================
	// Mode capture

	// The jumper synchroniser still holds its reset value for two edges after reset.
	// This shifter counts those edges, so that the strap is copied only once it is valid.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_reg <= 2'b00;
		end else begin
			settle_reg <= {settle_reg[0], 1'b1};
		end
	end

	// Jumper latched once.
	// The strap is copied on the third edge after reset and then held until the next reset.
	// Until then the sender refuses bytes and the strobe pin rests high.
	// In the strobe-high mode the pin therefore falls once when the mode settles.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_taken_reg <= 1'b0;
			mode_reg <= PPP_MODE_STROBE_LOW;
		end else if (settle_reg[1] && !mode_taken_reg) begin
			mode_taken_reg <= 1'b1;
			mode_reg <= ppp_mode_t'(jmp_sync_reg);
		end
	end

	// ==========================================
	// Status decode

	assign busy_now = ~stat_sync_reg[PPP_BUSY_BIT];

	// Status bits are interpreted per the selected convention.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_reg <= '0;
		end else begin
			status_reg.busy <= busy_now;
			status_reg.selected <= stat_sync_reg[PPP_SELECT_BIT];
			status_reg.paper_empty <= (mode_reg == PPP_MODE_STROBE_LOW) &
				~stat_sync_reg[PPP_FAULT_BIT];
			status_reg.interface_valid <= (mode_reg == PPP_MODE_STROBE_HIGH) &
				stat_sync_reg[PPP_FAULT_BIT];
			status_reg.data_demand <= (mode_reg == PPP_MODE_STROBE_HIGH) &
				stat_sync_reg[PPP_HANDSHAKE_BIT];
			status_reg.acknowledge <= (mode_reg == PPP_MODE_STROBE_LOW) &
				~stat_sync_reg[PPP_HANDSHAKE_BIT];
		end
	end

	// ==========================================
	// Sender

	// A byte is accepted only when idle and the mode is settled.
	assign send_ready_out = (state_reg == PPP_IDLE) && mode_taken_reg;

	// A byte is taken on an edge where the host offers it and the sender is free.
	assign take_now = send_valid_in && send_ready_out;

	// The settle or strobe period has run out when the counter rests at zero.
	assign cnt_done = (cnt_reg == '0);

	// Strobe only when free.
	// The strobe starts once the byte has settled and the synchronised busy line is clear.
	assign strobe_start = (state_reg == PPP_SETUP) && cnt_done && !busy_now;

	// Setup then strobe.
	// Sequence state: idle, settle the byte on the pins, then strobe it to the printer.
	// Busy is only looked at when the settle time ends; busy during the strobe does not cut it.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= PPP_IDLE;
		end else begin
			case (state_reg)
				PPP_IDLE: begin
					if (take_now) begin
						state_reg <= PPP_SETUP;
					end
				end
				PPP_SETUP: begin
					if (strobe_start) begin
						state_reg <= PPP_STROBE;
					end
				end
				PPP_STROBE: begin
					if (cnt_done) begin
						state_reg <= PPP_IDLE;
					end
				end
				default: begin
					state_reg <= PPP_IDLE;
				end
			endcase
		end
	end

	// Cycle counter: loaded with the settle time on a take and with the strobe width when
	// the strobe starts; otherwise it counts down and rests at zero.
	// A waiting sender keeps it at zero, so a late strobe still gets its full width.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= '0;
		end else if (take_now) begin
			cnt_reg <= PPP_CNT_W'(PPP_SETUP_CYC - 1);
		end else if (strobe_start) begin
			cnt_reg <= PPP_CNT_W'(PPP_STROBE_CYC - 1);
		end else if (!cnt_done) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// Byte held steady.
	// The data byte changes only on a take, so it stands through settle and strobe.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			byte_reg <= PPP_DATA_RST;
		end else if (take_now) begin
			byte_reg <= send_byte_in;
		end
	end

	// Strobe pulse timing.
	// The strobe rises once the settle time has ended and busy is clear, and falls when its own width has run out.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strobe_reg <= 1'b0;
		end else if (strobe_start) begin
			strobe_reg <= 1'b1;
		end else if (state_reg != PPP_STROBE || cnt_done) begin
			strobe_reg <= 1'b0;
		end
	end

	// ==========================================
	// Pin drive

	assign printer_byte_out = byte_reg;

	// Strobe polarity by mode.
	// Until the mode is settled the pin rests high, the idle level of the strobe-low mode.
	always_comb begin
		ctrl_pins_out = PPP_CTRL_RST;
		if (mode_reg == PPP_MODE_STROBE_LOW) begin
			ctrl_pins_out[PPP_STROBE_BIT] = ~(strobe_reg & mode_taken_reg);
		end else begin
			ctrl_pins_out[PPP_STROBE_BIT] = strobe_reg;
		end
	end

	// Decoded status and the latched mode leave straight from their registers.
	assign status_out = status_reg;
	assign mode_out = mode_reg;

endmodule : ppp_printer_port
`default_nettype wire

// >>> dv/ppp_printer_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_printer_model (
	input wire logic clk_in,
	input wire logic act_in,
	input wire logic [7:0] byte_in,
	output logic [7:4] pins_out,
	output logic got_out
);
	logic [8:0] st_reg = 9'h000;
	logic was_reg = 1'b0;
	// Printer status and handshake.
	// The printer takes the byte and stays busy for a time set by it.
	always @(posedge clk_in) begin
		was_reg <= act_in;
		if (got_out)
			st_reg <= {byte_in[2:0], byte_in[7:2]};
		else if (st_reg[5:0] != 6'h00)
			st_reg <= st_reg - 9'h001;
	end
	// Busy is low-true; the upper status lines echo the last byte.
	assign got_out = act_in && !was_reg;
	assign pins_out = {st_reg[8:6], st_reg[5:0] == 6'h00};
endmodule : ppp_printer_model
`default_nettype wire

// >>> dv/ppp_printer_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_printer_port_properties (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic mode_jumper_in,
	input wire logic [7:4] status_pins_in,
	input wire logic send_valid_in,
	input wire logic [7:0] send_byte_in,
	input wire logic send_ready_out,
	input wire logic [7:0] printer_byte_out,
	input wire logic [3:0] ctrl_pins_out,
	input wire ppp_pkg::ppp_mode_t mode_out
);
	logic act, tk;
	// Strobe is active at the mode's level; tk marks a taken byte.
	assign act = ctrl_pins_out[0] == mode_out;
	assign tk = send_valid_in && send_ready_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_idle; send_ready_out |-> !act; endproperty
	a_idle: assert property (p_idle) else $error("strobe");
	property p_spare; ctrl_pins_out[3:1] == 3'h0; endproperty
	a_spare: assert property (p_spare) else $error("spare");
	property p_take; tk |=> printer_byte_out == $past(send_byte_in); endproperty
	a_take: assert property (p_take) else $error("take");
	property p_hold; !tk |=> $stable(printer_byte_out); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_setup; tk |=> (!act)[*8]; endproperty
	a_setup: assert property (p_setup) else $error("early");
	property p_len; $rose(act) && !send_ready_out |-> ##19 act ##1 !act; endproperty
	a_len: assert property (p_len) else $error("width");
	property p_back; $fell(act) |-> send_ready_out; endproperty
	a_back: assert property (p_back) else $error("ready");
	property p_mode; send_ready_out |=> $stable(mode_out); endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_jumper; send_ready_out |-> mode_out == mode_jumper_in; endproperty
	a_jumper: assert property (p_jumper) else $error("jumper");
	// The strobe starts only if the busy pin was high three samples before it shows.
	property p_busy; $rose(act) |-> $past(status_pins_in[4], 3); endproperty
	a_busy: assert property (p_busy) else $error("busy");
	cover property (tk);
	cover property ($rose(act));
	cover property ($fell(act));
endmodule : ppp_printer_port_properties
`default_nettype wire

// >>> dv/ppp_printer_port_test.sv
`timescale 1ns/1ps
`default_nettype none
bind ppp_printer_port ppp_printer_port_properties i_chk (.clk_in, .rst_n_in, .mode_jumper_in,
	.status_pins_in, .send_valid_in, .send_byte_in, .send_ready_out, .printer_byte_out,
	.ctrl_pins_out, .mode_out);
module ppp_printer_port_test;
	import ppp_pkg::*;
	logic clk_in = 0, rst_n_in = 0, mode_jumper_in = 0, send_valid_in = 0, send_ready_out, got;
	logic [7:0] send_byte_in = 8'h00, printer_byte_out, q[$];
	logic [7:4] status_pins_in;
	logic [3:0] ctrl_pins_out;
	ppp_status_t status_out;
	ppp_mode_t mode_out;
	int error_cnt = 0, compares = 0;
	ppp_printer_port i_dut (.clk_in, .rst_n_in, .mode_jumper_in, .send_valid_in, .send_byte_in,
		.send_ready_out, .status_pins_in, .printer_byte_out, .ctrl_pins_out, .status_out, .mode_out);
	// The printer ignores the strobe pin until the port has taken the jumper's mode.
	ppp_printer_model i_prn (.clk_in,
		.act_in(ctrl_pins_out[0] == mode_out && mode_out == mode_jumper_in),
		.byte_in(printer_byte_out), .pins_out(status_pins_in), .got_out(got));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask : chk
	task automatic final_report;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	// Clock, watchdog, and the byte the printer takes at each strobe.
	initial forever #25 clk_in = ~clk_in;
	initial #300000 begin
		error_cnt++;
		final_report();
	end
	always @(posedge clk_in) if (got) chk(printer_byte_out, q.pop_front());
	// Both jumper settings: random bytes against a slow printer, then status.
	initial begin
		void'($urandom(97));
		for (int m = 0; m < 2; m++) begin
			mode_jumper_in = m[0];
			rst_n_in = 0;
			repeat (16) @(negedge clk_in);
			rst_n_in = 1;
			repeat (4) @(negedge clk_in);
			chk({mode_out, ctrl_pins_out}, {m[0], 3'h0, !m[0]});
			repeat (6) begin
				for (int n = 0; n < 300 && send_ready_out !== 1; n++) @(negedge clk_in);
				chk(send_ready_out, 1);
				send_byte_in = 8'($urandom);
				q.push_back(send_byte_in);
				send_valid_in = 1;
				@(negedge clk_in);
				send_valid_in = 0;
			end
			repeat (150) @(negedge clk_in);
			chk(status_out, {1'b0, send_byte_in[0], !m[0] && !send_byte_in[1],
				m[0] && send_byte_in[1], m[0] && send_byte_in[2], !m[0] && !send_byte_in[2]});
			chk(8'(q.size()), 8'h00);
		end
		final_report();
	end
endmodule : ppp_printer_port_test
`default_nettype wire

// >>> include/ppp_pkg.sv
// ==========================================
// Printer parallel port package
package ppp_pkg;

	// Port widths and bit positions of the control/status port.
	localparam int PPP_DATA_W = 8;
	localparam int PPP_STROBE_BIT = 0;
	localparam int PPP_BUSY_BIT = 4;
	localparam int PPP_SELECT_BIT = 5;
	localparam int PPP_FAULT_BIT = 6;
	localparam int PPP_HANDSHAKE_BIT = 7;

	// Reset values.
	localparam logic [7:0] PPP_DATA_RST = 8'h00;
	localparam logic [3:0] PPP_CTRL_RST = 4'h0;

	// Strobe pulse width and settle time in ns, and derived cycle counts at 20 MHz.
	localparam int PPP_CLK_NS = 50;
	localparam int PPP_SETUP_NS = 1000;
	localparam int PPP_STROBE_NS = 1000;
	localparam int PPP_SETUP_CYC = (PPP_SETUP_NS + PPP_CLK_NS - 1) / PPP_CLK_NS;
	localparam int PPP_STROBE_CYC = (PPP_STROBE_NS + PPP_CLK_NS - 1) / PPP_CLK_NS;
	localparam int PPP_CNT_W = 8;

	// Printer conventions selected by the board jumper.
	typedef enum logic {
		PPP_MODE_STROBE_LOW = 1'b0,
		PPP_MODE_STROBE_HIGH = 1'b1
	} ppp_mode_t;

	// Decoded printer status, true means asserted.
	typedef struct packed {
		logic busy;
		logic selected;
		logic paper_empty;
		logic interface_valid;
		logic data_demand;
		logic acknowledge;
	} ppp_status_t;

	// Sender states.
	typedef enum logic [1:0] {
		PPP_IDLE = 2'b00,
		PPP_SETUP = 2'b01,
		PPP_STROBE = 2'b10
	} ppp_state_t;

endpackage : ppp_pkg
